// File: logic/usbep_ctrl.sv
// Purpose: Enable, interrupt flags and masks, resume path and endpoint 0 control
// Assumes: Serial engine events arrive as one-cycle pulses on core_clk
// Notes: Registers reached over a plain strobe port, read data one cycle later
//
// Our own choices: the address map and the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module usbep_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire usbep_pkg::usbep_bus_s bus,
    output logic [7:0] regRdata,
    // Serial engine side
    input wire usbep_pkg::usbep_sie_s sie,
    output usbep_pkg::usbep_hs_s hs,
    output logic epAccept,
    output logic ep0DirIn,
    output logic devAddressed,
    output logic ctrlEnabled,
    // CPU interrupt side
    input wire logic port2Req,
    output logic vectorSixReq,
    output logic port0Req
);
    import usbep_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] ctrl_q, regRdata_q;
    logic [3:0] cflag_q, cmask_q, index_q;
    logic [5:0] iflag_q, oflag_q, imask_q, omask_q;
    logic [2:0] cpuflag_q;
    logic [6:0] devAddr_q, rxCount_q;
    usbep_ep0_e state_q;
    usbep_hs_s hs_q;
    logic outRdy_q, inRdy_q, sentStall_q, dataEnd_q, setupEnd_q, sendStall_q;
    logic hasData_q, dirIn_q, txState_q, addrSet_q, epAccept_q, vecSix_q, port0Req_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic live, wrCtrl, csSel, wrCs, ep0Tok, inTok0, outTok0, txStatus, rxStatus;
    logic errStall, premature, stallSent, ep0Evt, oversize, setupOk;
    logic [3:0] cEvt;
    logic [5:0] iEvt, oEvt;

    assign live = rst_n && ctrl_q[CTRL_EN];
    assign wrCtrl = bus.wr && (bus.addr == ADDR_CTRL);
    assign csSel = (index_q == INDEX_EP0);
    assign wrCs = bus.wr && (bus.addr == ADDR_EP0CS) && csSel;
    assign ep0Tok = sie.tokValid && (sie.tokEp == INDEX_EP0);
    assign inTok0 = ep0Tok && sie.inTok;
    assign outTok0 = ep0Tok && sie.outTok;
    // Status stages: opposite direction token after the last data packet
    assign txStatus = (state_q == EP0_TX) && dataEnd_q && !inRdy_q;
    assign rxStatus = (state_q == EP0_RX) && dataEnd_q && !outRdy_q;
    assign oversize = sie.outRcvd && (sie.outCount > EP0_MAXPKT);
    assign setupOk = sie.setupRcvd && (sie.outCount == SETUP_LEN);
    assign errStall = (outTok0 && rxStatus)
        || (inTok0 && txStatus)
        || ((inTok0 || outTok0) && sendStall_q)
        || (oversize && (state_q == EP0_RX));
    assign premature = ((state_q == EP0_TX) && !dataEnd_q && outTok0)
        || ((state_q == EP0_RX) && !dataEnd_q && inTok0)
        || (setupOk && (state_q != EP0_IDLE));
    assign stallSent = live && errStall;
    assign ep0Evt = live && ((setupOk || (sie.outRcvd && !oversize && state_q == EP0_RX))
        || sie.inSent || sie.statusDone || errStall || premature);
    assign cEvt = live ? {sie.sof, sie.busReset, sie.resume, sie.suspend} : 4'h0;
    assign iEvt = live ? {sie.inEpDone, ep0Evt} : 6'h00;
    assign oEvt = live ? {sie.outEpDone, 1'b0} : 6'h00;

    // ----------------------------------------
    // Control register, reset only by rst_n
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_q <= {3'h0, bus.wdata[4:0]};
        end
    end

    // ----------------------------------------
    // Masks and address
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!live) begin
            cmask_q <= CMASK_RST;
            imask_q <= IMASK_RST;
            omask_q <= OMASK_RST;
            devAddr_q <= 7'h00;
            addrSet_q <= 1'b0;
            index_q <= 4'h0;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_CMASK: cmask_q <= bus.wdata[3:0];
                ADDR_IMASK: imask_q <= bus.wdata[5:0];
                ADDR_OMASK: omask_q <= {bus.wdata[5:1], 1'b0};
                ADDR_DEVADDR: begin
                    devAddr_q <= bus.wdata[6:0];
                    addrSet_q <= |bus.wdata[6:0];
                end
                ADDR_INDEX: index_q <= bus.wdata[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Sticky flags, clear on read, set wins
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!live) begin
            cflag_q <= 4'h0;
            iflag_q <= 6'h00;
            oflag_q <= 6'h00;
        end else begin
            // Read clears whole register; same-cycle events survive
            cflag_q <= ((bus.rd && bus.addr == ADDR_CFLAG) ? 4'h0 : cflag_q) | cEvt;
            iflag_q <= ((bus.rd && bus.addr == ADDR_IFLAG) ? 6'h00 : iflag_q) | iEvt;
            oflag_q <= ((bus.rd && bus.addr == ADDR_OFLAG) ? 6'h00 : oflag_q) | oEvt;
        end
    end

    // ----------------------------------------
    // CPU level flags, write one to clear
    // ----------------------------------------
    logic busHit;
    logic resumeHit;
    assign busHit = |(cEvt & cmask_q) || |(iEvt & imask_q) || |(oEvt & omask_q);
    // Edge select zero means rising edge, the only one resume can wake on
    assign resumeHit = cEvt[CF_RESUME] && ctrl_q[CTRL_HNIBIE] && !ctrl_q[CTRL_EDGE];

    always_ff @(posedge core_clk) begin
        if (!live) begin
            cpuflag_q <= 3'h0;
        end else begin
            cpuflag_q[CPU_BUSFLAG] <= busHit || (cpuflag_q[CPU_BUSFLAG]
                && !(bus.wr && bus.addr == ADDR_CPUFLAG && bus.wdata[CPU_BUSFLAG]));
            cpuflag_q[CPU_P0FLAG] <= resumeHit || (cpuflag_q[CPU_P0FLAG]
                && !(bus.wr && bus.addr == ADDR_CPUFLAG && bus.wdata[CPU_P0FLAG]));
            cpuflag_q[CPU_RESUME] <= cEvt[CF_RESUME] || (cpuflag_q[CPU_RESUME]
                && !(bus.wr && bus.addr == ADDR_CPUFLAG && bus.wdata[CPU_RESUME]));
        end
    end

    // ----------------------------------------
    // Endpoint 0 state
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!live) begin
            state_q <= EP0_IDLE;
            txState_q <= 1'b0;
            hasData_q <= 1'b0;
            dirIn_q <= 1'b0;
        end else if (errStall || premature || sie.statusDone) begin
            state_q <= EP0_IDLE;
            txState_q <= 1'b0;
            if (setupOk) begin
                hasData_q <= sie.setupHasData;
                dirIn_q <= sie.setupDirIn;
            end
        end else if (setupOk) begin
            hasData_q <= sie.setupHasData;
            dirIn_q <= sie.setupDirIn;
        end else if (wrCs && bus.wdata[CS_CLROUT] && state_q == EP0_IDLE) begin
            case (state_q)
                EP0_IDLE: begin
                    if (hasData_q && !bus.wdata[CS_DATAEND] && !dataEnd_q) begin
                        // One direction per transfer, shared buffer
                        state_q <= dirIn_q ? EP0_TX : EP0_RX;
                        txState_q <= dirIn_q;
                    end
                end
                default: state_q <= state_q;
            endcase
        end
    end

    // ----------------------------------------
    // Endpoint 0 status bits
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!live) begin
            outRdy_q <= 1'b0;
            inRdy_q <= 1'b0;
            sentStall_q <= 1'b0;
            dataEnd_q <= 1'b0;
            setupEnd_q <= 1'b0;
            sendStall_q <= 1'b0;
            rxCount_q <= 7'h00;
        end else begin
            if (setupOk || (sie.outRcvd && !oversize && state_q == EP0_RX)) begin
                outRdy_q <= 1'b1;
                rxCount_q <= sie.outCount;
            end else if (wrCs && bus.wdata[CS_CLROUT]) begin
                outRdy_q <= 1'b0;
            end
            if (sie.inSent || premature || errStall) begin
                inRdy_q <= 1'b0;
            end else if (wrCs && bus.wdata[CS_INRDY]) begin
                inRdy_q <= 1'b1;
            end
            if (stallSent) begin
                sentStall_q <= 1'b1;
            end else if (wrCs && bus.wdata[CS_SENTSTALL]) begin
                sentStall_q <= 1'b0;
            end
            if (sie.statusDone || errStall || premature) begin
                dataEnd_q <= 1'b0;
            end else if (wrCs && bus.wdata[CS_DATAEND]) begin
                dataEnd_q <= 1'b1;
            end
            if (premature) begin
                setupEnd_q <= 1'b1;
            end else if (wrCs && bus.wdata[CS_CLRSETUP]) begin
                setupEnd_q <= 1'b0;
            end
            if (stallSent) begin
                sendStall_q <= 1'b0;
            end else if (wrCs) begin
                sendStall_q <= bus.wdata[CS_SENDSTALL];
            end
        end
    end

    // ----------------------------------------
    // Handshake answer and endpoint gating
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!live) begin
            hs_q <= '0;
            epAccept_q <= 1'b0;
        end else begin
            hs_q.stall <= errStall;
            hs_q.nak <= !errStall && ((inTok0 && !inRdy_q && !rxStatus)
                || (outTok0 && (outRdy_q || state_q == EP0_IDLE)) || premature);
            hs_q.sendData <= !errStall && !premature && inTok0 && (inRdy_q || rxStatus);
            hs_q.ack <= (sie.outRcvd && !oversize) || setupOk;
            // Only endpoint 0 answers before an address is set
            epAccept_q <= sie.tokValid && ((sie.tokEp == INDEX_EP0) || (devAddr_q != 7'h00));
        end
    end

    // ----------------------------------------
    // CPU requests
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vecSix_q <= 1'b0;
            port0Req_q <= 1'b0;
        end else begin
            // Vector six is shared; handler must also check port two
            vecSix_q <= (cpuflag_q[CPU_BUSFLAG] && ctrl_q[CTRL_BUSIE]) || port2Req;
            port0Req_q <= cpuflag_q[CPU_P0FLAG] && ctrl_q[CTRL_PORT_ZERO_CPU_ENABLE];
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdata_q <= 8'h00;
        end else if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: regRdata_q <= ctrl_q;
                ADDR_CFLAG: regRdata_q <= {4'h0, cflag_q};
                ADDR_IFLAG: regRdata_q <= {2'h0, iflag_q};
                ADDR_OFLAG: regRdata_q <= {2'h0, oflag_q};
                ADDR_CMASK: regRdata_q <= {4'h0, cmask_q};
                ADDR_IMASK: regRdata_q <= {2'h0, imask_q};
                ADDR_OMASK: regRdata_q <= {2'h0, omask_q};
                ADDR_CPUFLAG: regRdata_q <= {5'h00, cpuflag_q};
                ADDR_DEVADDR: regRdata_q <= {1'b0, devAddr_q};
                ADDR_INDEX: regRdata_q <= {4'h0, index_q};
                ADDR_EP0CS: regRdata_q <= csSel ? {2'h0, sendStall_q, setupEnd_q, dataEnd_q,
                    sentStall_q, inRdy_q, outRdy_q} : 8'h00;
                ADDR_EP0CNT: regRdata_q <= {1'b0, rxCount_q};
                default: regRdata_q <= 8'h00;
            endcase
        end else begin
            regRdata_q <= 8'h00;
        end
    end

    assign regRdata = regRdata_q;
    assign hs = hs_q;
    assign epAccept = epAccept_q;
    assign ep0DirIn = txState_q;
    assign devAddressed = addrSet_q;
    assign ctrlEnabled = ctrl_q[CTRL_EN];
    assign vectorSixReq = vecSix_q;
    assign port0Req = port0Req_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_disable_clears: assert property (@(posedge core_clk) disable iff (!rst_n)
        !ctrl_q[CTRL_EN] |=> (iflag_q == 6'h00) && (state_q == EP0_IDLE))
        else $error("disable left flags or state");
    a_mask_reset: assert property (@(posedge core_clk) disable iff (!rst_n)
        $rose(live) |-> (cmask_q == 4'h6) && (imask_q == 6'h3f))
        else $error("mask reset value wrong");
    a_read_clears: assert property (@(posedge core_clk) disable iff (!live)
        (bus.rd && bus.addr == ADDR_IFLAG && !ep0Evt && sie.inEpDone == 5'h00)
        |=> iflag_q == 6'h00)
        else $error("flag read did not clear");
    a_event_kept: assert property (@(posedge core_clk) disable iff (!live)
        (bus.rd && bus.addr == ADDR_IFLAG && ep0Evt) |=> iflag_q[0])
        else $error("event lost on clearing read");
    a_addr_gate: assert property (@(posedge core_clk) disable iff (!live)
        (sie.tokValid && sie.tokEp != 4'h0 && devAddr_q == 7'h00) |=> !epAccept_q)
        else $error("endpoint served without address");
    a_stall_flag: assert property (@(posedge core_clk) disable iff (!live)
        errStall |=> hs_q.stall && sentStall_q && iflag_q[0])
        else $error("protocol error without stall");
    a_out_after_end: assert property (@(posedge core_clk) disable iff (!live)
        (outTok0 && rxStatus) |-> ##1 hs_q.stall ##1 !hs_q.stall)
        else $error("late OUT token not stalled");
    a_in_after_end: assert property (@(posedge core_clk) disable iff (!live)
        (inTok0 && txStatus) |=> hs_q.stall && !hs_q.sendData)
        else $error("late IN token not stalled");
    a_in_clear: assert property (@(posedge core_clk) disable iff (!live)
        sie.inSent |=> !inRdy_q && iflag_q[0])
        else $error("IN ready not cleared after send");
    a_premature_end: assert property (@(posedge core_clk) disable iff (!live)
        (premature && !errStall) |=> setupEnd_q && (state_q == EP0_IDLE))
        else $error("premature end not handled");
    a_cpu_flag: assert property (@(posedge core_clk) disable iff (!live)
        (ep0Evt && !imask_q[0] && !busHit && !cpuflag_q[CPU_BUSFLAG])
        |=> !cpuflag_q[CPU_BUSFLAG] && iflag_q[0])
        else $error("masked event set CPU flag");
    a_oversize_stall: assert property (@(posedge core_clk) disable iff (!live)
        (oversize && state_q == EP0_RX) |=> hs_q.stall && !$rose(outRdy_q))
        else $error("oversize packet accepted");
endmodule : usbep_ctrl

`default_nettype wire

// File: logic/usbep_pkg.sv
// Purpose: Shared constants and carrier types for the control endpoint and irq block
// Assumes: 8-bit register port, one core clock
// Notes: Offsets are byte addresses on the plain register port

package usbep_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFLAG = 8'h01;
    localparam logic [7:0] ADDR_IFLAG = 8'h02;
    localparam logic [7:0] ADDR_OFLAG = 8'h04;
    localparam logic [7:0] ADDR_CMASK = 8'h06;
    localparam logic [7:0] ADDR_IMASK = 8'h07;
    localparam logic [7:0] ADDR_OMASK = 8'h09;
    localparam logic [7:0] ADDR_CPUFLAG = 8'h0b;
    localparam logic [7:0] ADDR_DEVADDR = 8'h0e;
    localparam logic [7:0] ADDR_INDEX = 8'h0f;
    localparam logic [7:0] ADDR_EP0CS = 8'h11;
    localparam logic [7:0] ADDR_EP0CNT = 8'h16;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_EN = 0;
    localparam int CTRL_BUSIE = 1;
    localparam int CTRL_PORT_ZERO_CPU_ENABLE = 2;
    localparam int CTRL_HNIBIE = 3;
    localparam int CTRL_EDGE = 4;
    localparam int CF_SUSPEND = 0;
    localparam int CF_RESUME = 1;
    localparam int CF_BUSRESET = 2;
    localparam int CF_SOF = 3;
    localparam int CPU_BUSFLAG = 0;
    localparam int CPU_P0FLAG = 1;
    localparam int CPU_RESUME = 2;
    localparam int CS_OUTRDY = 0;
    localparam int CS_INRDY = 1;
    localparam int CS_SENTSTALL = 2;
    localparam int CS_DATAEND = 3;
    localparam int CS_SETUPEND = 4;
    localparam int CS_SENDSTALL = 5;
    localparam int CS_CLROUT = 6;
    localparam int CS_CLRSETUP = 7;
    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] CMASK_RST = 4'h6;
    localparam logic [5:0] IMASK_RST = 6'h3f;
    localparam logic [5:0] OMASK_RST = 6'h3e;
    localparam logic [6:0] EP0_MAXPKT = 7'h20;
    localparam logic [6:0] SETUP_LEN = 7'h08;
    localparam logic [3:0] INDEX_EP0 = 4'h0;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {EP0_IDLE, EP0_TX, EP0_RX} usbep_ep0_e;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usbep_bus_s;
    typedef struct packed {
        logic tokValid;
        logic [3:0] tokEp;
        logic inTok;
        logic outTok;
        logic setupRcvd;
        logic setupHasData;
        logic setupDirIn;
        logic outRcvd;
        logic [6:0] outCount;
        logic inSent;
        logic statusDone;
        logic sof;
        logic suspend;
        logic resume;
        logic busReset;
        logic [4:0] inEpDone;
        logic [4:0] outEpDone;
    } usbep_sie_s;
    typedef struct packed {
        logic stall;
        logic nak;
        logic sendData;
        logic ack;
    } usbep_hs_s;
endpackage : usbep_pkg

// File: testbench/usbep_ctrl_tb_top.sv
// Purpose: Register and event sequences for the control endpoint block
// Assumes: Strobe register port, read data in the cycle after the strobe
// Notes: Event flags are clear-on-read, so each event flag register is read once per check; CPU flags are write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module usbep_ctrl_tb_top;
    import usbep_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic port2Req = 1'b0;
    usbep_bus_s bus = '0;
    usbep_sie_s sie, ev;
    usbep_hs_s hs, got;
    logic [7:0] regRdata;
    logic epAccept, ep0DirIn, devAddressed, ctrlEnabled, vectorSixReq, port0Req;
    int badCount = 0;
    int nChecks = 0;
    always #25 core_clk = ~core_clk;
    usbep_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .regRdata(regRdata),
        .sie(sie), .hs(hs), .epAccept(epAccept), .ep0DirIn(ep0DirIn),
        .devAddressed(devAddressed), .ctrlEnabled(ctrlEnabled), .port2Req(port2Req),
        .vectorSixReq(vectorSixReq), .port0Req(port0Req));
    usbep_host_model host (.core_clk(core_clk), .sie(sie), .hs(hs));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        nChecks++;
        if (g !== e) begin
            badCount++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        chk(regRdata & m, e & m);
    endtask : rd
    task automatic tok(input logic [3:0] ep, input logic isIn);
        ev = '0;
        ev.tokValid = 1'b1;
        ev.tokEp = ep;
        ev.inTok = isIn;
        ev.outTok = !isIn;
        host.send(ev, got);
    endtask : tok
    task automatic give_verdict();
        if (badCount == 0 && nChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, 8'h00);
        wr(ADDR_CTRL, 8'h03);
        @(negedge core_clk);
        chk(ctrlEnabled, 8'h01);
        rd(ADDR_CMASK, 8'h06);
        rd(ADDR_IMASK, 8'h3f);
        rd(ADDR_OMASK, 8'h3e);
        rd(8'h03, 8'h00);
        tok(4'h2, 1'b1);
        chk(epAccept, 8'h00);
        wr(ADDR_DEVADDR, 8'h7f);
        @(negedge core_clk);
        chk(devAddressed, 8'h01);
        tok(4'h2, 1'b1);
        chk(epAccept, 8'h01);
        // Short setup must be dropped, full one accepted
        ev = '0;
        ev.setupRcvd = 1'b1;
        ev.setupHasData = 1'b1;
        ev.setupDirIn = 1'b1;
        ev.outCount = 7'h07;
        host.send(ev, got);
        chk(got.ack, 8'h00);
        rd(ADDR_IFLAG, 8'h00);
        ev.outCount = 7'h08;
        host.send(ev, got);
        chk(got.ack, 8'h01);
        rd(ADDR_EP0CS, 8'h01);
        rd(ADDR_EP0CNT, 8'h08);
        rd(ADDR_IFLAG, 8'h01);
        rd(ADDR_IFLAG, 8'h00);
        wr(ADDR_EP0CS, 8'h40);
        // Nothing loaded yet, so the IN token is refused
        tok(4'h0, 1'b1);
        chk(got.nak, 8'h01);
        wr(ADDR_EP0CS, 8'h02);
        @(negedge core_clk);
        chk(ep0DirIn, 8'h01);
        tok(4'h0, 1'b1);
        chk(got.sendData, 8'h01);
        chk(epAccept, 8'h01);
        ev = '0;
        ev.inSent = 1'b1;
        host.send(ev, got);
        rd(ADDR_EP0CS, 8'h00, 8'h02);
        rd(ADDR_IFLAG, 8'h01);
        // Last packet, then one IN too many
        wr(ADDR_EP0CS, 8'h0a);
        tok(4'h0, 1'b1);
        ev = '0;
        ev.inSent = 1'b1;
        host.send(ev, got);
        tok(4'h0, 1'b1);
        chk(got.stall, 8'h01);
        chk(ep0DirIn, 8'h00);
        rd(ADDR_EP0CS, 8'h04, 8'h04);
        repeat (3) @(negedge core_clk);
        chk(vectorSixReq, 8'h01);
        wr(ADDR_CPUFLAG, 8'h01);
        repeat (3) @(negedge core_clk);
        chk(vectorSixReq, 8'h00);
        @(posedge core_clk);
        port2Req <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk(vectorSixReq, 8'h01);
        // Port two cleared before the shared flag
        @(posedge core_clk);
        port2Req <= 1'b0;
        wr(ADDR_CPUFLAG, 8'h01);
        repeat (3) @(negedge core_clk);
        chk(vectorSixReq, 8'h00);
        // Masked source flags but raises no request
        wr(ADDR_OMASK, 8'h00);
        ev = '0;
        ev.outEpDone = 5'h01;
        host.send(ev, got);
        repeat (3) @(negedge core_clk);
        chk(vectorSixReq, 8'h00);
        rd(ADDR_OFLAG, 8'h02);
        wr(ADDR_CTRL, 8'h0f);
        ev = '0;
        ev.resume = 1'b1;
        host.send(ev, got);
        repeat (3) @(negedge core_clk);
        chk(port0Req, 8'h01);
        rd(ADDR_CFLAG, 8'h02);
        rd(ADDR_CPUFLAG, 8'h04, 8'h04);
        // Falling edge select must not wake on resume
        wr(ADDR_CTRL, 8'h1f);
        wr(ADDR_CPUFLAG, 8'h02);
        host.send(ev, got);
        repeat (3) @(negedge core_clk);
        chk(port0Req, 8'h00);
        rd(ADDR_CPUFLAG, 8'h04, 8'h06);
        // Address clears a cycle after enable drops
        wr(ADDR_CTRL, 8'h00);
        repeat (2) @(negedge core_clk);
        chk(devAddressed, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        rd(ADDR_OMASK, 8'h3e);
        rd(ADDR_DEVADDR, 8'h00);
        // OUT data stage: oversize packet is stalled
        ev = '0;
        ev.setupRcvd = 1'b1;
        ev.setupHasData = 1'b1;
        ev.outCount = 7'h08;
        host.send(ev, got);
        wr(ADDR_EP0CS, 8'h40);
        @(negedge core_clk);
        chk(ep0DirIn, 8'h00);
        ev = '0;
        ev.outRcvd = 1'b1;
        ev.outCount = 7'h21;
        host.send(ev, got);
        chk(got.stall, 8'h01);
        rd(ADDR_EP0CS, 8'h04, 8'h05);
        give_verdict();
    end
    // Run needs well under 1000 cycles
    initial begin
        #200000;
        badCount++;
        give_verdict();
    end
endmodule : usbep_ctrl_tb_top
`default_nettype wire

// File: testbench/usbep_host_model.sv
// Purpose: Host side stand-in that drives serial engine events
// Assumes: Events are one-cycle pulses on core_clk
// Notes: Count field shows the inverse value between packets, never a stale copy
`timescale 1ns/1ps
`default_nettype none
module usbep_host_model (
    // Clock
    input wire logic core_clk,
    // Engine side
    output var usbep_pkg::usbep_sie_s sie,
    input wire usbep_pkg::usbep_hs_s hs
);
    import usbep_pkg::*;
    initial sie = '0;
    // One pulse; the answer is sampled a cycle later, when it stands
    task automatic send(input usbep_sie_s s, output usbep_hs_s got);
        usbep_sie_s z;
        z = '0;
        z.outCount = ~s.outCount;
        @(posedge core_clk);
        sie <= s;
        @(posedge core_clk);
        sie <= z;
        @(negedge core_clk);
        got = hs;
    endtask : send
endmodule : usbep_host_model
`default_nettype wire
